//--- hw/vtx_irq.sv
// sticky event flags, write-one-to-clear, mask and level interrupt
`include "vtx_params.svh"
module vtx_irq (
    input  wire logic                 sys_clk,   // system clock
    input  wire logic                 rstn,      // sync reset, low
    input  wire logic [`VTX_EV_W-1:0] set_ev,    // event pulses
    input  wire logic [`VTX_EV_W-1:0] hw_clr,    // clear from hardware
    input  wire logic                 w1c_we,    // status write strobe
    input  wire logic                 mask_we,   // mask write strobe
    input  wire logic [`VTX_EV_W-1:0] wdata,     // write data
    output logic      [`VTX_EV_W-1:0] stat,      // sticky flags
    output logic      [`VTX_EV_W-1:0] mask,      // mask, 1 enables
    output logic                      irq        // level interrupt
);
    logic [`VTX_EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic                 irq_r, irq_nxt;

    always_comb begin
        stat_nxt = stat_r & ~hw_clr;
        if (w1c_we) begin
            stat_nxt = stat_nxt & ~wdata;
        end
        // an event in the clearing cycle survives
        stat_nxt = stat_nxt | set_ev;
        mask_nxt = mask_we ? wdata : mask_r;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stat_r <= '0;
            mask_r <= '0;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign stat = stat_r;
    assign mask = mask_r;
    assign irq  = irq_r;
endmodule : vtx_irq

//--- hw/vtx_mem.sv
// 128-byte fifo storage in flip-flops, one write port, two read ports
`include "vtx_params.svh"
module vtx_mem (
    input  wire logic                  sys_clk, // system clock
    input  wire logic                  rstn,    // sync reset, low
    input  wire logic                  we,      // write strobe
    input  wire logic [`VTX_IDX_W-1:0] waddr,   // write index
    input  wire vtx_pkg::vtx_byte_t    wdata,   // write byte
    input  wire logic [`VTX_IDX_W-1:0] raddr_a, // read index a
    output vtx_pkg::vtx_byte_t         rdata_a, // read byte a
    input  wire logic [`VTX_IDX_W-1:0] raddr_b, // read index b
    output vtx_pkg::vtx_byte_t         rdata_b  // read byte b
);
    import vtx_pkg::*;

    vtx_byte_t mem_r   [`VTX_DEPTH];
    vtx_byte_t mem_nxt [`VTX_DEPTH];

    always_comb begin
        for (int i = 0; i < `VTX_DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (we) begin
            mem_nxt[waddr] = wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < `VTX_DEPTH; i++) begin
            mem_r[i] <= rstn ? mem_nxt[i] : `VTX_RST_BYTE;
        end
    end

    assign rdata_a = mem_r[raddr_a];
    assign rdata_b = mem_r[raddr_b];
endmodule : vtx_mem

//--- hw/vtx_params.svh
// constants for the voice transmit fifo block: offsets, fields, sizes
`ifndef VTX_PARAMS_SVH
`define VTX_PARAMS_SVH

// register indices; the byte address is four times the index
`define VTX_IDX_DATA      14'h2750
`define VTX_IDX_MUTE      14'h2751
`define VTX_IDX_CTRL      14'h2752
`define VTX_IDX_RDPTR     14'h2753
`define VTX_IDX_WRPTR     14'h2754
`define VTX_IDX_STAT      14'h275A
`define VTX_IDX_SIZE      14'h275B
`define VTX_IDX_IRQ_STAT  14'h275C
`define VTX_IDX_IRQ_MASK  14'h275D
`define VTX_IDX_MEM_FIRST 14'h2600
`define VTX_IDX_MEM_LAST  14'h267F

// control register fields
`define VTX_CTL_FILL      0
`define VTX_CTL_CLR       1
`define VTX_CTL_MUTE      2
`define VTX_CTL_GO        3

// status register fields
`define VTX_STS_POP       2
`define VTX_STS_PUSH      3
`define VTX_STS_BUSY      4

// event bits of the interrupt status and mask registers
`define VTX_EV_OVF        0
`define VTX_EV_UNF        1
`define VTX_EV_FILL_DONE  2
`define VTX_EV_DMA_DONE   3
`define VTX_EV_W          4
`define VTX_EV_PTR_CLR    4'h3

// storage geometry and reset values
`define VTX_DEPTH         128
`define VTX_IDX_W         7
`define VTX_FILL_LAST     7'h7F
`define VTX_RST_BYTE      8'h00
`define VTX_RST_WORD      32'h00000000

`endif

//--- hw/vtx_pkg.sv
// types shared by the voice transmit fifo block
package vtx_pkg;
    typedef logic [7:0] vtx_byte_t;
    typedef logic [7:0] vtx_ptr_t;
    typedef enum logic [0:0] {
        VTX_DMA_IDLE = 1'b0,
        VTX_DMA_RUN  = 1'b1
    } vtx_dma_st_t;
    typedef enum logic [0:0] {
        VTX_FILL_IDLE = 1'b0,
        VTX_FILL_RUN  = 1'b1
    } vtx_fill_st_t;
endpackage : vtx_pkg

//--- hw/vtx_top.sv
// voice transmit fifo with register port, mute, fill and dma launch
`include "vtx_params.svh"
module vtx_top (
    input  wire logic               sys_clk,         // 40 MHz clock
    input  wire logic               rstn,            // sync reset, low
    input  wire logic [15:0]        avs_address,     // byte address
    input  wire logic               avs_read,        // read request
    input  wire logic               avs_write,       // write request
    input  wire logic [31:0]        avs_writedata,   // write data
    input  wire logic [3:0]         avs_byteenable,  // byte lanes
    output logic      [31:0]        avs_readdata,    // read data
    output logic                    avs_waitrequest, // stall
    input  wire logic               enc_valid,       // encoder byte
    input  wire vtx_pkg::vtx_byte_t enc_data,        // encoder data
    output logic                    mac_valid,       // byte to mac
    output vtx_pkg::vtx_byte_t      mac_data,        // byte to mac
    input  wire logic               mac_ready,       // mac accepts
    output logic                    irq              // interrupt
);
    import vtx_pkg::*;

    function automatic logic f_full(vtx_ptr_t rp, vtx_ptr_t wp);
        f_full = (rp[6:0] == wp[6:0]) && (rp[7] != wp[7]);
    endfunction : f_full

    function automatic logic f_empty(vtx_ptr_t rp, vtx_ptr_t wp);
        f_empty = (rp == wp);
    endfunction : f_empty

    function automatic vtx_ptr_t f_inc(vtx_ptr_t p);
        f_inc = vtx_ptr_t'(p + 8'h01);
    endfunction : f_inc

    logic          wait_r, wait_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    vtx_byte_t     mute_byte_r, mute_byte_nxt;
    logic          mute_en_r, mute_en_nxt;
    vtx_ptr_t      rp_r, rp_nxt, wp_r, wp_nxt;
    vtx_byte_t     size_r, size_nxt;
    logic          push_act_r, push_act_nxt, pop_act_r, pop_act_nxt;
    vtx_fill_st_t  fill_st_r, fill_st_nxt;
    logic [6:0]    fill_idx_r, fill_idx_nxt;
    vtx_dma_st_t   dma_st_r, dma_st_nxt;
    vtx_byte_t     dma_left_r, dma_left_nxt;
    logic          mac_valid_r, mac_valid_nxt;
    vtx_byte_t     mac_data_r, mac_data_nxt;

    logic [13:0]   idx;
    logic          is_port, is_win, fill_busy, enc_push, bus_go, bus_wr;
    logic          bus_push, bus_pop, full, empty, push_req, push_ok;
    logic          pop_ok, dma_pop, ovf, unf, ctl_wr, clr_pulse;
    logic          fill_go, dma_go, fill_done, dma_done;
    logic          mem_we;
    logic [6:0]    mem_waddr;
    vtx_byte_t     mem_wdata, rd_a, rd_b;
    logic [`VTX_EV_W-1:0] ev_set, ev_stat, ev_mask;

    // bus decode and arbitration against encoder and fill
    always_comb begin
        idx       = avs_address[15:2];
        is_port   = (idx == `VTX_IDX_DATA);
        is_win    = (idx >= `VTX_IDX_MEM_FIRST) && (idx <= `VTX_IDX_MEM_LAST);
        fill_busy = (fill_st_r == VTX_FILL_RUN);
        enc_push  = enc_valid && !fill_busy;
        // storage accesses wait while the encoder or fill owns the port
        bus_go    = (avs_read || avs_write) && wait_r
                    && !((is_port || is_win) && (enc_push || fill_busy));
        bus_wr    = bus_go && avs_write && avs_byteenable[0];
        bus_push  = bus_wr && is_port;
        bus_pop   = bus_go && avs_read && is_port;
        ctl_wr    = bus_wr && (idx == `VTX_IDX_CTRL);
        clr_pulse = ctl_wr && avs_writedata[`VTX_CTL_CLR];
        fill_go   = ctl_wr && avs_writedata[`VTX_CTL_FILL] && !fill_busy;
        dma_go    = ctl_wr && avs_writedata[`VTX_CTL_GO];
        full      = f_full(rp_r, wp_r);
        empty     = f_empty(rp_r, wp_r);
        push_req  = enc_push || bus_push;
        push_ok   = push_req && !full;
        ovf       = push_req && full;
        unf       = bus_pop && empty;
        dma_pop   = (dma_st_r == VTX_DMA_RUN) && (dma_left_r != 8'h00)
                    && (!mac_valid_r || mac_ready) && !empty
                    && !bus_pop && !fill_busy;
        pop_ok    = (bus_pop && !empty) || dma_pop;
    end

    // storage write port: fill, then push, then the direct window
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = wp_r[6:0];
        mem_wdata = enc_push ? enc_data : avs_writedata[7:0];
        if (fill_busy) begin
            mem_we    = 1'b1;
            mem_waddr = fill_idx_r;
            mem_wdata = mute_byte_r;
        end else if (push_ok) begin
            mem_we    = 1'b1;
        end else if (bus_wr && is_win) begin
            mem_we    = 1'b1;
            mem_waddr = idx[6:0];
            mem_wdata = avs_writedata[7:0];
        end
    end

    vtx_mem u_mem (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr_a (rp_r[6:0]),
        .rdata_a (rd_a),
        .raddr_b (idx[6:0]),
        .rdata_b (rd_b)
    );

    // pointers, registers, fill and dma sequencing
    always_comb begin
        rp_nxt        = pop_ok ? f_inc(rp_r) : rp_r;
        wp_nxt        = push_ok ? f_inc(wp_r) : wp_r;
        mute_byte_nxt = mute_byte_r;
        mute_en_nxt   = mute_en_r;
        size_nxt      = size_r;
        if (bus_wr && idx == `VTX_IDX_RDPTR) begin
            rp_nxt = avs_writedata[7:0];
        end
        if (bus_wr && idx == `VTX_IDX_WRPTR) begin
            wp_nxt = avs_writedata[7:0];
        end
        if (clr_pulse) begin
            rp_nxt = 8'h00;
            wp_nxt = 8'h00;
        end
        if (bus_wr && idx == `VTX_IDX_MUTE) begin
            mute_byte_nxt = avs_writedata[7:0];
        end
        if (ctl_wr) begin
            mute_en_nxt = avs_writedata[`VTX_CTL_MUTE];
        end
        if (bus_wr && idx == `VTX_IDX_SIZE) begin
            size_nxt = avs_writedata[7:0];
        end
        push_act_nxt = push_ok;
        pop_act_nxt  = pop_ok;

        fill_st_nxt  = fill_st_r;
        fill_idx_nxt = fill_idx_r;
        fill_done    = 1'b0;
        unique case (fill_st_r)
            VTX_FILL_IDLE: begin
                if (fill_go) begin
                    fill_st_nxt  = VTX_FILL_RUN;
                    fill_idx_nxt = 7'h00;
                end
            end
            VTX_FILL_RUN: begin
                fill_idx_nxt = 7'(fill_idx_r + 7'h01);
                if (fill_idx_r == `VTX_FILL_LAST) begin
                    fill_st_nxt = VTX_FILL_IDLE;
                    fill_done   = 1'b1;
                end
            end
        endcase

        dma_st_nxt   = dma_st_r;
        dma_left_nxt = dma_pop ? 8'(dma_left_r - 8'h01) : dma_left_r;
        dma_done     = 1'b0;
        unique case (dma_st_r)
            VTX_DMA_IDLE: begin
                if (dma_go) begin
                    dma_st_nxt   = VTX_DMA_RUN;
                    dma_left_nxt = size_r;
                end
            end
            VTX_DMA_RUN: begin
                if (dma_left_r == 8'h00) begin
                    dma_st_nxt = VTX_DMA_IDLE;
                    dma_done   = 1'b1;
                end
            end
        endcase

        mac_valid_nxt = mac_valid_r && !mac_ready;
        mac_data_nxt  = mac_data_r;
        if (dma_pop) begin
            mac_valid_nxt = 1'b1;
            mac_data_nxt  = mute_en_r ? mute_byte_r : rd_a;
        end
    end

    // bus answer: stall until accepted, one cycle if storage is not blocked, then waitrequest low for one edge
    always_comb begin
        wait_nxt  = !bus_go;
        rdata_nxt = rdata_r;
        if (bus_go) begin
            rdata_nxt = `VTX_RST_WORD;
            if (is_win) begin
                rdata_nxt[7:0] = rd_b;
            end else begin
                unique case (idx)
                    `VTX_IDX_DATA:     rdata_nxt[7:0] = rd_a;
                    `VTX_IDX_MUTE:     rdata_nxt[7:0] = mute_byte_r;
                    // go, clear and fill bits are write-only
                    `VTX_IDX_CTRL:     rdata_nxt[`VTX_CTL_MUTE] = mute_en_r;
                    `VTX_IDX_RDPTR:    rdata_nxt[7:0] = rp_r;
                    `VTX_IDX_WRPTR:    rdata_nxt[7:0] = wp_r;
                    `VTX_IDX_STAT: begin
                        rdata_nxt[`VTX_STS_BUSY] = fill_busy;
                        rdata_nxt[`VTX_STS_PUSH] = push_act_r;
                        rdata_nxt[`VTX_STS_POP]  = pop_act_r;
                    end
                    `VTX_IDX_SIZE:     rdata_nxt[7:0] = size_r;
                    `VTX_IDX_IRQ_STAT: rdata_nxt[3:0] = ev_stat;
                    `VTX_IDX_IRQ_MASK: rdata_nxt[3:0] = ev_mask;
                    default:           rdata_nxt = `VTX_RST_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wait_r      <= 1'b1;
            rdata_r     <= `VTX_RST_WORD;
            mute_byte_r <= `VTX_RST_BYTE;
            mute_en_r   <= 1'b0;
            rp_r        <= `VTX_RST_BYTE;
            wp_r        <= `VTX_RST_BYTE;
            size_r      <= `VTX_RST_BYTE;
            push_act_r  <= 1'b0;
            pop_act_r   <= 1'b0;
            fill_st_r   <= VTX_FILL_IDLE;
            fill_idx_r  <= 7'h00;
            dma_st_r    <= VTX_DMA_IDLE;
            dma_left_r  <= `VTX_RST_BYTE;
            mac_valid_r <= 1'b0;
            mac_data_r  <= `VTX_RST_BYTE;
        end else begin
            wait_r      <= wait_nxt;
            rdata_r     <= rdata_nxt;
            mute_byte_r <= mute_byte_nxt;
            mute_en_r   <= mute_en_nxt;
            rp_r        <= rp_nxt;
            wp_r        <= wp_nxt;
            size_r      <= size_nxt;
            push_act_r  <= push_act_nxt;
            pop_act_r   <= pop_act_nxt;
            fill_st_r   <= fill_st_nxt;
            fill_idx_r  <= fill_idx_nxt;
            dma_st_r    <= dma_st_nxt;
            dma_left_r  <= dma_left_nxt;
            mac_valid_r <= mac_valid_nxt;
            mac_data_r  <= mac_data_nxt;
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[`VTX_EV_OVF]       = ovf;
        ev_set[`VTX_EV_UNF]       = unf;
        ev_set[`VTX_EV_FILL_DONE] = fill_done;
        ev_set[`VTX_EV_DMA_DONE]  = dma_done;
    end

    vtx_irq u_irq (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .set_ev  (ev_set),
        .hw_clr  (clr_pulse ? `VTX_EV_PTR_CLR : 4'h0),
        .w1c_we  (bus_wr && idx == `VTX_IDX_IRQ_STAT),
        .mask_we (bus_wr && idx == `VTX_IDX_IRQ_MASK),
        .wdata   (avs_writedata[3:0]),
        .stat    (ev_stat),
        .mask    (ev_mask),
        .irq     (irq)
    );

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;
    assign mac_valid       = mac_valid_r;
    assign mac_data        = mac_data_r;

    fill_span_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        fill_go |=> fill_busy [*8] ##120 fill_busy ##1 !fill_busy)
        else $error("fill busy not held for 128 cycles");
    fill_value_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        fill_busy |-> mem_we && mem_wdata == mute_byte_r)
        else $error("fill does not write the mute byte");
    clr_ptr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        clr_pulse |=> rp_r == 8'h00 && wp_r == 8'h00 && !ev_stat[`VTX_EV_UNF]
                      && ($past(ovf) || !ev_stat[`VTX_EV_OVF]))
        else $error("clear left pointers or flags set");
    dma_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dma_go && dma_st_r == VTX_DMA_IDLE)
            |=> dma_st_r == VTX_DMA_RUN && dma_left_r == $past(size_r))
        else $error("dma did not start with programmed size");
    push_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (push_ok && !clr_pulse && !(bus_wr && idx == `VTX_IDX_WRPTR))
            |=> wp_r == f_inc($past(wp_r)) && push_act_r)
        else $error("push did not advance write pointer");
    ovf_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (push_req && full && !clr_pulse && !(bus_wr && idx == `VTX_IDX_WRPTR))
            |=> ev_stat[`VTX_EV_OVF] && wp_r == $past(wp_r))
        else $error("push into full fifo not flagged");
    mute_path_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dma_pop && mute_en_r) |=> mac_valid && mac_data == $past(mute_byte_r))
        else $error("mute byte not substituted");
    pop_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        pop_act_r == $past(pop_ok) && (pop_act_r || !$past(dma_pop)))
        else $error("pop active flag wrong");
    bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus_go |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after acceptance");
endmodule : vtx_top

//--- verif/vtx_mac_sink.sv
// stand-in for the mac transmit fifo: takes bytes, may throttle
module vtx_mac_sink (
    input  wire logic               sys_clk,   // system clock
    input  wire logic               rstn,      // sync reset, low
    input  wire logic               mac_valid, // byte offered
    input  wire vtx_pkg::vtx_byte_t mac_data,  // offered byte
    output logic                    mac_ready, // accept strobe
    input  wire logic               stall_en   // throttle accepts
);
    timeunit 1ns;
    timeprecision 1ps;
    import vtx_pkg::*;
    vtx_byte_t   rx_q [$];
    logic [7:0]  lfsr_r;
    // irregular stalls catch a dma that drops bytes on backpressure
    always_ff @(posedge sys_clk) begin
        if (!rstn)
            lfsr_r <= 8'h01;
        else
            lfsr_r <= {lfsr_r[6:0],
                       lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
    assign mac_ready = !stall_en || lfsr_r[0];
    always @(posedge sys_clk) begin
        if (rstn && mac_valid && mac_ready)
            rx_q.push_back(mac_data);
    end
endmodule : vtx_mac_sink

//--- verif/vtx_top_bench.sv
// self-checking bench for the voice transmit fifo block
`include "vtx_params.svh"
module vtx_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import vtx_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        enc_valid = 1'b0;
    vtx_byte_t   enc_data = 8'h00;
    logic        mac_valid;
    vtx_byte_t   mac_data;
    logic        mac_ready;
    logic        irq;
    logic        stall_en = 1'b0;
    integer      error_cnt = 0;
    integer      total_checks = 0;
    integer      seed = 32'ha4b34f7e;
    integer      mrp = 0;
    integer      mwp = 0;
    integer      i;
    vtx_byte_t   mm [128];
    vtx_byte_t   q;
    vtx_byte_t   d;
    logic [13:0] ridx [10] = '{`VTX_IDX_MUTE, `VTX_IDX_CTRL, `VTX_IDX_RDPTR,
        `VTX_IDX_WRPTR, `VTX_IDX_STAT, `VTX_IDX_SIZE, `VTX_IDX_IRQ_STAT,
        `VTX_IDX_IRQ_MASK, 14'h2755, `VTX_IDX_MEM_LAST};

    always #12.5 sys_clk = ~sys_clk;

    vtx_top DUT (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .enc_valid(enc_valid), .enc_data(enc_data), .mac_valid(mac_valid),
        .mac_data(mac_data), .mac_ready(mac_ready), .irq(irq));
    vtx_mac_sink mac (.sys_clk(sys_clk), .rstn(rstn), .mac_valid(mac_valid),
        .mac_data(mac_data), .mac_ready(mac_ready), .stall_en(stall_en));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon access; waits up to 400 cycles for the slave, then counts a mismatch
    task automatic acc(input logic w, input logic [13:0] idx,
                       input vtx_byte_t dv);
        integer n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h000000, dv};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 400);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 400) chk(8'h00, 8'hFF);
    endtask : acc

    task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask : rdc

    task automatic mpush(input vtx_byte_t v);
        mm[mwp % 128] = v;
        mwp = (mwp + 1) % 256;
    endtask : mpush

    task automatic enc(input vtx_byte_t v);
        @(posedge sys_clk);
        enc_valid <= 1'b1;
        enc_data <= v;
        @(posedge sys_clk);
        enc_valid <= 1'b0;
        mpush(v);
    endtask : enc

    task automatic wait_rx(input integer n);
        integer k;
        for (k = 0; k < 600 && mac.rx_q.size() < n; k++) @(posedge sys_clk);
        if (mac.rx_q.size() < n) chk(8'h00, 8'hFF);
    endtask : wait_rx

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (ridx[k]) rdc(ridx[k], 8'h00);
        $display("test reset values done");
        for (i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            acc(1'b1, `VTX_IDX_DATA, d);
            mpush(d);
        end
        rdc(`VTX_IDX_WRPTR, mwp[7:0]);
        for (i = 0; i < 5; i++) begin
            acc(1'b0, `VTX_IDX_DATA, 8'h00);
            chk(q, mm[mrp % 128]);
            mrp++;
        end
        rdc(`VTX_IDX_RDPTR, mrp[7:0]);
        acc(1'b0, `VTX_IDX_DATA, 8'h00);
        rdc(`VTX_IDX_IRQ_STAT, 8'h02);
        acc(1'b1, `VTX_IDX_IRQ_MASK, 8'h02);
        @(posedge sys_clk);
        chk({7'h00, irq}, 8'h01);
        acc(1'b1, `VTX_IDX_IRQ_MASK, 8'h00);
        @(posedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        acc(1'b1, `VTX_IDX_WRPTR, 8'h80);
        acc(1'b1, `VTX_IDX_RDPTR, 8'h00);
        acc(1'b1, `VTX_IDX_DATA, 8'h77);
        rdc(`VTX_IDX_IRQ_STAT, 8'h03);
        rdc(`VTX_IDX_WRPTR, 8'h80);
        acc(1'b1, `VTX_IDX_CTRL, 8'h02);
        rdc(`VTX_IDX_RDPTR, 8'h00);
        rdc(`VTX_IDX_WRPTR, 8'h00);
        rdc(`VTX_IDX_IRQ_STAT, 8'h00);
        mrp = 0;
        mwp = 0;
        $display("test pointers and flags done");
        for (i = 0; i < 4; i++) enc(8'($random(seed)));
        rdc(`VTX_IDX_WRPTR, 8'h04);
        for (i = 0; i < 4; i++) rdc(14'(`VTX_IDX_MEM_FIRST + i), mm[i]);
        stall_en <= 1'b1;
        acc(1'b1, `VTX_IDX_SIZE, 8'h04);
        rdc(`VTX_IDX_SIZE, 8'h04);
        acc(1'b1, `VTX_IDX_CTRL, 8'h08);
        wait_rx(4);
        for (i = 0; i < 4; i++) begin
            chk(mac.rx_q.pop_front(), mm[mrp % 128]);
            mrp++;
        end
        rdc(`VTX_IDX_CTRL, 8'h00);
        rdc(`VTX_IDX_RDPTR, mrp[7:0]);
        rdc(`VTX_IDX_IRQ_STAT, 8'h08);
        acc(1'b1, `VTX_IDX_IRQ_STAT, 8'h08);
        $display("test encoder and dma done");
        d = 8'($random(seed));
        acc(1'b1, `VTX_IDX_MUTE, d);
        enc(8'($random(seed)));
        enc(8'($random(seed)));
        acc(1'b1, `VTX_IDX_SIZE, 8'h02);
        acc(1'b1, `VTX_IDX_CTRL, 8'h0C);
        wait_rx(2);
        chk(mac.rx_q.pop_front(), d);
        chk(mac.rx_q.pop_front(), d);
        mrp = mrp + 2;
        rdc(`VTX_IDX_CTRL, 8'h04);
        rdc(`VTX_IDX_RDPTR, mrp[7:0]);
        acc(1'b1, `VTX_IDX_MEM_FIRST + 14'h0005, 8'hA5);
        rdc(`VTX_IDX_MEM_FIRST + 14'h0005, 8'hA5);
        $display("test mute done");
        acc(1'b1, `VTX_IDX_MUTE, 8'h3C);
        acc(1'b1, `VTX_IDX_CTRL, 8'h01);
        rdc(`VTX_IDX_STAT, 8'h10);
        for (i = 0; i < 300 && q[`VTX_EV_FILL_DONE] !== 1'b1; i++)
            acc(1'b0, `VTX_IDX_IRQ_STAT, 8'h00);
        chk({7'h00, q[`VTX_EV_FILL_DONE]}, 8'h01);
        rdc(`VTX_IDX_STAT, 8'h00);
        rdc(`VTX_IDX_CTRL, 8'h00);
        rdc(`VTX_IDX_MEM_FIRST, 8'h3C);
        rdc(`VTX_IDX_MEM_LAST, 8'h3C);
        $display("test fill done");
        report_and_stop();
    end

    // the whole run needs a few hundred cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : vtx_top_bench
